/* hw/mhc_top.sv */
// host-facing control of the serial radio modem: APB registers, standby
// sequencing, shared trace/standby pin, filter-bank select and power mode
// assumes radio status comes from logic on clk_i; host pins are asynchronous
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module mhc_top
	import mhc_pkg::*;
#(
	parameter int BAUD_DIV_P = BAUD_DIV
)(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// host pins
	input wire logic hard_restore_n_i,
	input wire logic host_rx_i,
	output logic host_tx_o,
	input wire logic shared_pin_i,
	output logic shared_pin_o,
	output logic shared_pin_oe_n_o,
	output logic trace_serial_out_o,
	// filter bank
	output logic filter_select_hi_o,
	output logic filter_select_lo_o,
	// radio
	input wire mhc_radio_t radio_i,
	output logic radio_enable_o,
	output logic link_drop_o,
	output mhc_pwr_t power_mode_o
);

	if (BAUD_DIV_P < BAUD_DIV_MIN)
	begin
		$error("baud divider too small for the serial port");
	end

	function automatic logic apb_hit(input logic [AW-1:0] a);
		apb_hit = (a == OFF_CTRL) || (a == OFF_PINFN) || (a == OFF_STATUS)
			|| (a == OFF_TXDATA) || (a == OFF_RXDATA);
	endfunction

	function automatic mhc_pwr_t radio_pwr(input mhc_radio_t r);
		if (r.tx)
			radio_pwr = PWR_TX;
		else if (r.rx)
			radio_pwr = PWR_RX;
		else if (r.listen)
			radio_pwr = PWR_LISTEN;
		else
			radio_pwr = PWR_IDLE;
	endfunction

	// pin synchronisers
	logic restore_n_s, rx_s, pin_s;
	logic sys_rst;

	mhc_sync #(
		.W(3),
		.RST_VAL(3'h7)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({hard_restore_n_i, host_rx_i, shared_pin_i}),
		.q_o({restore_n_s, rx_s, pin_s})
	);

	// the restore pin resets everything except its own synchroniser
	assign sys_rst = rst_i | ~restore_n_s;

	// serial port
	mhc_byte_t tx_req, rx_byte;
	logic tx_busy;
	logic uart_en_q, uart_en_d;

	mhc_uart #(
		.DIV(BAUD_DIV_P)
	) u_uart (
		.clk_i(clk_i),
		.rst_i(sys_rst),
		// the port stops on the same edge as the radio, so no bit leaks into standby
		.en_i(uart_en_d),
		.rx_i(rx_s),
		.tx_o(host_tx_o),
		.tx_req_i(tx_req),
		.tx_busy_o(tx_busy),
		.rx_byte_o(rx_byte)
	);

	// registers and apb
	logic [1:0] fsel_q, fsel_d;
	mhc_pinfn_t pinfn_q, pinfn_d;
	logic [7:0] rxdata_q, rxdata_d;
	logic rxv_q, rxv_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic access, done, wr, rd_rx;
	mhc_state_t st_q, st_d;
	mhc_pwr_t pwr_q, pwr_d;
	logic [31:0] status;

	assign access = psel_i & penable_i;
	assign done = access & pready_q;
	assign wr = done & pwrite_i;
	assign rd_rx = done & ~pwrite_i & (paddr_i == OFF_RXDATA);

	always_comb
	begin
		status = '0;
		status[ST_STATE_LSB +: 2] = st_q;
		status[ST_PWR_LSB +: 3] = pwr_q;
		status[ST_PIN_BIT] = pin_s;
		status[ST_RXV_BIT] = rxv_q;
		status[ST_TXB_BIT] = tx_busy;
	end

	always_comb
	begin
		fsel_d = fsel_q;
		pinfn_d = pinfn_q;
		rxdata_d = rxdata_q;
		prdata_d = prdata_q;
		pslverr_d = 1'b0;
		// one wait state so read data leaves a flop
		pready_d = access & ~pready_q;
		tx_req = '{valid: 1'b0, data: pwdata_i[7:0]};
		if (access && !pready_q)
		begin
			pslverr_d = !apb_hit(paddr_i);
			case (paddr_i)
				OFF_CTRL: prdata_d = {30'h0, fsel_q};
				OFF_PINFN: prdata_d = {30'h0, pinfn_q};
				OFF_STATUS: prdata_d = status;
				OFF_RXDATA: prdata_d = {24'h0, rxdata_q};
				default: prdata_d = 32'h0;
			endcase
		end
		if (wr)
		begin
			case (paddr_i)
				OFF_CTRL:
				begin
					// the undefined code is refused, the old filter stays
					if (pwdata_i[1:0] != FSEL_BAD)
						fsel_d = pwdata_i[1:0];
				end
				OFF_PINFN:
				begin
					if (pwdata_i[1:0] != 2'h3)
						pinfn_d = mhc_pinfn_t'(pwdata_i[1:0]);
				end
				OFF_TXDATA: tx_req.valid = !tx_busy && uart_en_q;
				default: ;
			endcase
		end
		// host commands arrive on the serial link; they win over an apb write
		if (rx_byte.valid)
		begin
			case (rx_byte.data)
				CMD_PIN_OFF: pinfn_d = PIN_OFF;
				CMD_PIN_TRACE: pinfn_d = PIN_TRACE;
				CMD_PIN_STANDBY: pinfn_d = PIN_STANDBY;
				default: rxdata_d = rx_byte.data;
			endcase
		end
		// a new byte wins over the read that clears the flag
		rxv_d = (rx_byte.valid && rx_byte.data != CMD_PIN_OFF
			&& rx_byte.data != CMD_PIN_TRACE && rx_byte.data != CMD_PIN_STANDBY)
			|| (rxv_q && !rd_rx);
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst)
		begin
			fsel_q <= FSEL_RST;
			pinfn_q <= PINFN_RST;
			rxdata_q <= 8'h00;
			rxv_q <= 1'b0;
			prdata_q <= 32'h0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			fsel_q <= fsel_d;
			pinfn_q <= pinfn_d;
			rxdata_q <= rxdata_d;
			rxv_q <= rxv_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// standby sequencing
	logic radio_en_q, radio_en_d;
	logic drop_q, drop_d;

	always_comb
	begin
		st_d = st_q;
		drop_d = 1'b0;
		case (st_q)
			ST_ACTIVE:
			begin
				// the pin level only counts once standby is the chosen function
				if (pinfn_q == PIN_STANDBY && !pin_s)
					st_d = ST_ENTER;
			end
			ST_ENTER:
			begin
				st_d = ST_STANDBY;
				drop_d = 1'b1;
			end
			ST_STANDBY:
			begin
				if (pin_s || pinfn_q != PIN_STANDBY)
					st_d = ST_WAKE;
			end
			ST_WAKE: st_d = ST_ACTIVE;
			default: st_d = ST_ACTIVE;
		endcase
		// radio and serial port run only in the active state
		radio_en_d = (st_d == ST_ACTIVE);
		uart_en_d = (st_d == ST_ACTIVE);
		pwr_d = (st_q == ST_ACTIVE) ? radio_pwr(radio_i) : PWR_STANDBY;
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst)
		begin
			st_q <= ST_ACTIVE;
			drop_q <= 1'b0;
			radio_en_q <= 1'b1;
			uart_en_q <= 1'b1;
			pwr_q <= PWR_IDLE;
		end
		else
		begin
			st_q <= st_d;
			drop_q <= drop_d;
			radio_en_q <= radio_en_d;
			uart_en_q <= uart_en_d;
			pwr_q <= pwr_d;
		end
	end

	// shared pin and packet trace
	logic busy_q, busy_d;
	logic pin_o_q, pin_o_d, pin_oe_n_q, pin_oe_n_d;
	logic tser_q, tser_d;
	logic trace_on;

	assign trace_on = (pinfn_q == PIN_TRACE);

	always_comb
	begin
		busy_d = radio_i.rx | radio_i.tx;
		// a one-cycle sync marks the start of each radio frame
		pin_o_d = trace_on & busy_d & ~busy_q;
		// the pin is an input unless trace owns it
		pin_oe_n_d = !trace_on;
		tser_d = trace_on & busy_d;
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst)
		begin
			busy_q <= 1'b0;
			pin_o_q <= 1'b0;
			pin_oe_n_q <= 1'b1;
			tser_q <= 1'b0;
		end
		else
		begin
			busy_q <= busy_d;
			pin_o_q <= pin_o_d;
			pin_oe_n_q <= pin_oe_n_d;
			tser_q <= tser_d;
		end
	end

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign shared_pin_o = pin_o_q;
	assign shared_pin_oe_n_o = pin_oe_n_q;
	assign trace_serial_out_o = tser_q;
	assign filter_select_hi_o = fsel_q[1];
	assign filter_select_lo_o = fsel_q[0];
	assign radio_enable_o = radio_en_q;
	assign link_drop_o = drop_q;
	assign power_mode_o = pwr_q;

endmodule

/* include/mhc_pkg.sv */
// constants, types and register map of the modem host control block
// assumes one 50 MHz clock and an APB master with 32-bit data
// How it works
// - filter pins: 00=H, 01=E, 10=U
// - never drive both filter pins high
// - standby enabled and request low enters standby
// - standby stops radio, serial link, drops connections
// - request released restarts interfaces without host help
// - hard restore low returns all power-on state except the pin synchroniser
// - serial link runs at 115,200 baud
// - after reset trace and standby both disabled
// - serial command enables trace or standby, never both
// - power mode follows radio activity automatically
package mhc_pkg;

	localparam int CLK_HZ = 50_000_000;
	localparam int BAUD = 115_200;
	localparam int BAUD_DIV = CLK_HZ / BAUD;
	localparam int BAUD_DIV_MIN = 16;

	localparam int AW = 8;
	localparam logic [AW-1:0] OFF_CTRL = 8'h00;
	localparam logic [AW-1:0] OFF_PINFN = 8'h04;
	localparam logic [AW-1:0] OFF_STATUS = 8'h08;
	localparam logic [AW-1:0] OFF_TXDATA = 8'h0C;
	localparam logic [AW-1:0] OFF_RXDATA = 8'h10;

	localparam int ST_STATE_LSB = 0;
	localparam int ST_PWR_LSB = 2;
	localparam int ST_PIN_BIT = 5;
	localparam int ST_RXV_BIT = 6;
	localparam int ST_TXB_BIT = 7;

	localparam logic [1:0] FSEL_H = 2'h0;
	localparam logic [1:0] FSEL_E = 2'h1;
	localparam logic [1:0] FSEL_U = 2'h2;
	localparam logic [1:0] FSEL_BAD = 2'h3;
	localparam logic [1:0] FSEL_RST = FSEL_H;

	// arbitrary command byte values
	localparam logic [7:0] CMD_PIN_OFF = 8'hA0;
	localparam logic [7:0] CMD_PIN_TRACE = 8'hA1;
	localparam logic [7:0] CMD_PIN_STANDBY = 8'hA2;

	typedef enum logic [1:0] {
		PIN_OFF = 2'h0,
		PIN_TRACE = 2'h1,
		PIN_STANDBY = 2'h2
	} mhc_pinfn_t;
	localparam mhc_pinfn_t PINFN_RST = PIN_OFF;

	typedef enum logic [1:0] {
		ST_ACTIVE = 2'h0,
		ST_ENTER = 2'h1,
		ST_STANDBY = 2'h3,
		ST_WAKE = 2'h2
	} mhc_state_t;

	typedef enum logic [2:0] {
		PWR_STANDBY = 3'h0,
		PWR_IDLE = 3'h1,
		PWR_LISTEN = 3'h2,
		PWR_RX = 3'h3,
		PWR_TX = 3'h4
	} mhc_pwr_t;

	typedef struct packed {
		logic listen;
		logic rx;
		logic tx;
	} mhc_radio_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} mhc_byte_t;

endpackage

/* hw/mhc_sync.sv */
// three-stage synchroniser for pins from outside the clock domain
// assumes inputs are asynchronous levels; output follows once stages 2 and 3 agree
`timescale 1ns/1ns
module mhc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
)(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// levels
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] s1_q, s2_q, s3_q, q_q;
	logic [W-1:0] q_d;

	always_comb
	begin
		// a bit only moves when the last two stages agree
		q_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q_q);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			q_q <= RST_VAL;
		end
		else
		begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q_q <= q_d;
		end
	end

	assign q_o = q_q;

endmodule

/* hw/mhc_uart.sv */
// 8N1 serial port for the host link
// assumes rx_i is already synchronised; en_i low holds both halves idle
`timescale 1ns/1ns
module mhc_uart
	import mhc_pkg::*;
#(
	parameter int DIV = BAUD_DIV
)(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	// line
	input wire logic rx_i,
	output logic tx_o,
	// byte streams
	input wire mhc_byte_t tx_req_i,
	output logic tx_busy_o,
	output mhc_byte_t rx_byte_o
);

	localparam int CW = $clog2(DIV + 1);
	localparam logic [CW-1:0] CNT_END = CW'(DIV - 1);
	localparam logic [CW-1:0] CNT_HALF = CW'(DIV / 2);

	logic [CW-1:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
	logic [3:0] tbit_q, tbit_d, rbit_q, rbit_d;
	logic [9:0] tsh_q, tsh_d;
	logic [7:0] rsh_q, rsh_d;
	logic tbusy_q, tbusy_d, txo_q, txo_d, rbusy_q, rbusy_d;
	mhc_byte_t rxo_q, rxo_d;

	always_comb
	begin
		tcnt_d = tcnt_q;
		tbit_d = tbit_q;
		tsh_d = tsh_q;
		tbusy_d = tbusy_q;
		if (!en_i)
		begin
			tbusy_d = 1'b0;
			tcnt_d = '0;
		end
		else if (!tbusy_q)
		begin
			if (tx_req_i.valid)
			begin
				tsh_d = {1'b1, tx_req_i.data, 1'b0};
				tbusy_d = 1'b1;
				tcnt_d = '0;
				tbit_d = 4'h0;
			end
		end
		else if (tcnt_q == CNT_END)
		begin
			tcnt_d = '0;
			tsh_d = {1'b1, tsh_q[9:1]};
			if (tbit_q == 4'h9)
				tbusy_d = 1'b0;
			else
				tbit_d = tbit_q + 4'h1;
		end
		else
			tcnt_d = tcnt_q + 1'b1;
		txo_d = tbusy_d ? tsh_d[0] : 1'b1;

		rcnt_d = rcnt_q;
		rbit_d = rbit_q;
		rsh_d = rsh_q;
		rbusy_d = rbusy_q;
		rxo_d = '{valid: 1'b0, data: rxo_q.data};
		if (!en_i)
			rbusy_d = 1'b0;
		else if (!rbusy_q)
		begin
			// start sampling half a bit after the falling edge
			if (!rx_i)
			begin
				rbusy_d = 1'b1;
				rcnt_d = CNT_HALF;
				rbit_d = 4'h0;
			end
		end
		else if (rcnt_q == CNT_END)
		begin
			rcnt_d = '0;
			rbit_d = rbit_q + 4'h1;
			if (rbit_q == 4'h0)
				rbusy_d = !rx_i;
			else if (rbit_q == 4'h9)
			begin
				rbusy_d = 1'b0;
				// a bad stop bit drops the byte
				rxo_d = '{valid: rx_i, data: rsh_q};
			end
			else
				rsh_d = {rx_i, rsh_q[7:1]};
		end
		else
			rcnt_d = rcnt_q + 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tcnt_q <= '0;
			tbit_q <= 4'h0;
			tsh_q <= 10'h3FF;
			tbusy_q <= 1'b0;
			txo_q <= 1'b1;
			rcnt_q <= '0;
			rbit_q <= 4'h0;
			rsh_q <= 8'h00;
			rbusy_q <= 1'b0;
			rxo_q <= '0;
		end
		else
		begin
			tcnt_q <= tcnt_d;
			tbit_q <= tbit_d;
			tsh_q <= tsh_d;
			tbusy_q <= tbusy_d;
			txo_q <= txo_d;
			rcnt_q <= rcnt_d;
			rbit_q <= rbit_d;
			rsh_q <= rsh_d;
			rbusy_q <= rbusy_d;
			rxo_q <= rxo_d;
		end
	end

	assign tx_o = txo_q;
	assign tx_busy_o = tbusy_q;
	assign rx_byte_o = rxo_q;

endmodule

/* bench/mhc_properties.sv */
// concurrent checks on the modem host control pins
// assumes a bind into mhc_top; synchronous reset rst_i
`timescale 1ns/1ns
module mhc_properties
	import mhc_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// watched pins
	input wire logic hard_restore_n_i,
	input wire mhc_radio_t radio_i,
	input wire logic host_tx_o,
	input wire logic shared_pin_o,
	input wire logic shared_pin_oe_n_o,
	input wire logic trace_serial_out_o,
	input wire logic filter_select_hi_o,
	input wire logic filter_select_lo_o,
	input wire logic radio_enable_o,
	input wire logic link_drop_o,
	input wire mhc_pwr_t power_mode_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// restore pin passes a synchroniser, so power decode is trusted only once it settled
	sequence s_live;
		hard_restore_n_i [*6] ##0 radio_enable_o [*2];
	endsequence
	a_fsel_not_both: assert property (!(filter_select_hi_o && filter_select_lo_o))
		else $error("filter select pins both high");
	a_drop_pulse: assert property (link_drop_o |=> !link_drop_o)
		else $error("link drop longer than one cycle");
	a_drop_then_off: assert property ($rose(link_drop_o) |-> ##[0:2] !radio_enable_o)
		else $error("radio still on after link drop");
	a_standby_power: assert property (!radio_enable_o [*3]
		|-> power_mode_o == PWR_STANDBY)
		else $error("power mode not standby while radio off");
	a_serial_idle: assert property (!radio_enable_o |-> host_tx_o)
		else $error("serial output active in standby");
	a_trace_drives: assert property (shared_pin_o || trace_serial_out_o
		|-> !shared_pin_oe_n_o)
		else $error("trace output without trace function");
	a_sync_pulse: assert property (shared_pin_o |=> !shared_pin_o)
		else $error("trace sync longer than one cycle");
	a_power_tx: assert property (s_live ##0 radio_i.tx ##1 radio_enable_o
		|-> power_mode_o == PWR_TX)
		else $error("power mode not tx");
	a_power_rx: assert property (s_live ##0 (radio_i.rx && !radio_i.tx) ##1 radio_enable_o
		|-> power_mode_o == PWR_RX)
		else $error("power mode not rx");
	a_restore_state: assert property (!hard_restore_n_i [*6] |-> !filter_select_hi_o
		&& !filter_select_lo_o && radio_enable_o && shared_pin_oe_n_o && power_mode_o == PWR_IDLE)
		else $error("restore did not return power-on state");
endmodule
bind mhc_top mhc_properties chk_u (.clk_i, .rst_i, .hard_restore_n_i, .radio_i, .host_tx_o,
	.shared_pin_o, .shared_pin_oe_n_o, .trace_serial_out_o, .filter_select_hi_o,
	.filter_select_lo_o, .radio_enable_o, .link_drop_o, .power_mode_o);

/* bench/mhc_host_model.sv */
// host controller model: serial sender, restore and standby pins
// assumes the bench calls its tasks right after a rising edge
`timescale 1ns/1ns
module mhc_host_model #(
	parameter int DIV = 16
)(
	// clock
	input wire logic clk_i,
	// serial lines
	input wire logic rx_i,
	output logic tx_o,
	// control pins
	output logic restore_n_o,
	output logic standby_n_o
);
	initial
	begin
		tx_o = 1'b1;
		restore_n_o = 1'b1;
		standby_n_o = 1'b1;
	end
	// 8N1, lsb first; gap adds idle bit times to model a slow host
	task send(input logic [7:0] b, input int gap);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			tx_o <= f[i];
			repeat (DIV) @(posedge clk_i);
		end
		repeat (gap * DIV) @(posedge clk_i);
	endtask
	// samples one frame mid-bit; call in the cycle its start bit begins
	task recv(output logic [9:0] f);
		repeat (DIV / 2) @(posedge clk_i);
		for (int i = 0; i < 10; i++)
		begin
			f[i] = rx_i;
			repeat (DIV) @(posedge clk_i);
		end
	endtask
	task standby(input logic n);
		standby_n_o <= n;
	endtask
	task restore(input int c);
		restore_n_o <= 1'b0;
		repeat (c) @(posedge clk_i);
		restore_n_o <= 1'b1;
	endtask
endmodule

/* bench/tb.sv */
// self-checking bench for mhc_top: apb master, host model, radio stimulus
// assumes a short bit divider so serial frames stay brief
`timescale 1ns/1ns
module tb;
	import mhc_pkg::*;
	localparam int DIV = 16;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o, pslverr_o, host_tx_o, shared_pin_o, shared_pin_oe_n_o, trace_serial_out_o;
	logic filter_select_hi_o, filter_select_lo_o, radio_enable_o, link_drop_o, h_rx, h_rst_n, h_sb_n;
	mhc_radio_t radio_i = '0;
	mhc_pwr_t power_mode_o, ep;
	localparam logic [31:0] STAT_IDLE = (32'h1 << ST_PIN_BIT) | (32'(PWR_IDLE) << ST_PWR_LSB);
	logic [7:0] rb;
	logic [9:0] fr;
	logic pb = 1'b0;
	logic [33:0] q[$];
	logic [33:0] e;
	int err_count = 0;
	int compares = 0;
	wire pin = !shared_pin_oe_n_o ? shared_pin_o : h_sb_n;
	initial
	begin
		forever #10 clk_i = ~clk_i;
	end
	mhc_top #(.BAUD_DIV_P(DIV)) dut_u (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .hard_restore_n_i(h_rst_n),
		.host_rx_i(h_rx), .host_tx_o, .shared_pin_i(pin), .shared_pin_o, .shared_pin_oe_n_o,
		.trace_serial_out_o, .filter_select_hi_o, .filter_select_lo_o, .radio_i,
		.radio_enable_o, .link_drop_o, .power_mode_o);
	mhc_host_model #(.DIV(DIV)) host_u (.clk_i, .rx_i(host_tx_o), .tx_o(h_rx),
		.restore_n_o(h_rst_n), .standby_n_o(h_sb_n));
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, x, g);
		end
	endtask
	task tally_and_finish;
		$display("mismatches %0d, compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// x holds {is_read, slverr, data}; the watcher below compares it
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] x);
		int n;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		q.push_back(x);
		@(posedge clk_i);
		penable_i <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (pready_o !== 1'b1 && n < 10);
		if (n >= 10)
		begin
			err_count++;
			tally_and_finish();
		end
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] d, input logic err);
		apb(1'b0, a, 32'h0, {1'b1, err, d});
	endtask
	always @(posedge clk_i)
		if (pready_o === 1'b1 && q.size() > 0)
		begin
			e = q.pop_front();
			chk("pslverr", 32'(e[32]), 32'(pslverr_o));
			if (e[33])
				chk("prdata", e[31:0], prdata_o);
		end
	initial
	begin
		#2_000_000;
		err_count++;
		tally_and_finish();
	end
	initial
	begin
		void'($urandom(29157));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("oe_n", 32'h1, 32'(shared_pin_oe_n_o));
		rd(OFF_PINFN, 32'(PINFN_RST), 1'b0);
		for (int v = 0; v < 4; v++)
		begin
			apb(1'b1, OFF_CTRL, 32'(v), 34'h0);
			rd(OFF_CTRL, (v < 3) ? 32'(v) : 32'h2, 1'b0);
			chk("filter", (v < 3) ? 32'(v) : 32'h2,
				{filter_select_hi_o, filter_select_lo_o});
		end
		rd(8'h20 | 8'($urandom_range(7) << 2), 32'h0, 1'b1);
		$display("test registers finished");
		host_u.standby(1'b0);
		repeat (10) @(posedge clk_i);
		chk("radio_enable", 32'h1, 32'(radio_enable_o));
		host_u.standby(1'b1);
		host_u.send(CMD_PIN_STANDBY, 3);
		repeat (20) @(posedge clk_i);
		rd(OFF_PINFN, 32'(PIN_STANDBY), 1'b0);
		host_u.standby(1'b0);
		for (int i = 0; i < 20 && radio_enable_o !== 1'b0; i++)
			@(posedge clk_i);
		chk("radio_enable", 32'h0, 32'(radio_enable_o));
		@(posedge clk_i);
		chk("link_drop", 32'h1, 32'(link_drop_o));
		repeat (3) @(posedge clk_i);
		chk("power", 32'(PWR_STANDBY), 32'(power_mode_o));
		host_u.standby(1'b1);
		for (int i = 0; i < 20 && radio_enable_o !== 1'b1; i++)
			@(posedge clk_i);
		chk("radio_enable", 32'h1, 32'(radio_enable_o));
		$display("test standby finished");
		host_u.send(CMD_PIN_TRACE, 0);
		repeat (20) @(posedge clk_i);
		rd(OFF_PINFN, 32'(PIN_TRACE), 1'b0);
		chk("oe_n", 32'h0, 32'(shared_pin_oe_n_o));
		for (int i = 0; i < 12; i++)
		begin
			radio_i <= mhc_radio_t'(3'($urandom));
			repeat (2) @(posedge clk_i);
			ep = radio_i.tx ? PWR_TX : radio_i.rx ? PWR_RX
				: radio_i.listen ? PWR_LISTEN : PWR_IDLE;
			chk("power", 32'(ep), 32'(power_mode_o));
			chk("trace", 32'(radio_i.rx | radio_i.tx), 32'(trace_serial_out_o));
			chk("trace_sync", 32'((radio_i.rx | radio_i.tx) & !pb), 32'(shared_pin_o));
			pb = radio_i.rx | radio_i.tx;
		end
		radio_i <= '0;
		host_u.send(CMD_PIN_OFF, 0);
		repeat (20) @(posedge clk_i);
		rd(OFF_PINFN, 32'(PIN_OFF), 1'b0);
		chk("oe_n", 32'h1, 32'(shared_pin_oe_n_o));
		$display("test trace finished");
		apb(1'b1, OFF_CTRL, 32'(FSEL_U), 34'h0);
		apb(1'b1, OFF_PINFN, 32'(PIN_TRACE), 34'h0);
		host_u.restore(8);
		repeat (6) @(posedge clk_i);
		rd(OFF_CTRL, 32'(FSEL_RST), 1'b0);
		rd(OFF_PINFN, 32'(PINFN_RST), 1'b0);
		chk("oe_n", 32'h1, 32'(shared_pin_oe_n_o));
		$display("test restore finished");
		// data bytes stay below the command codes so they land in the receive register
		rb = 8'($urandom_range(8'h9F));
		host_u.send(rb, 0);
		repeat (20) @(posedge clk_i);
		rd(OFF_STATUS, STAT_IDLE | (32'h1 << ST_RXV_BIT), 1'b0);
		rd(OFF_RXDATA, 32'(rb), 1'b0);
		rd(OFF_STATUS, STAT_IDLE, 1'b0);
		rb = 8'($urandom);
		apb(1'b1, OFF_TXDATA, 32'(rb), 34'h0);
		host_u.recv(fr);
		chk("host_tx", 32'({1'b1, rb, 1'b0}), 32'(fr));
		$display("test serial finished");
		tally_and_finish();
	end
endmodule
